// ===== common/rtc_timing_pkg.sv
/*
 * Constants shared by the timing-support block: register offsets, field
 * positions, reset values, repeat codes, time bases and hold times.
 * Assumes a 10 MHz system clock and a 32.768 kHz oscillator on a pin.
 */
package rtc_timing_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_WATCHDOG = 8'h09;
   localparam logic [7:0] ADDR_ALARM_MONTH_CTRL = 8'h0A;
   localparam logic [7:0] ADDR_AL_SEC = 8'h0E;
   localparam logic [7:0] ADDR_FLAGS = 8'h0F;
   localparam logic [7:0] ADDR_SQW = 8'h13;
   // ==========================================================
   // Field positions
   localparam int WD_STEER_POS = 7;
   localparam int AL_IRQ_EN_POS = 7;
   localparam int SQ_EN_POS = 6;
   localparam int BK_EN_POS = 5;
   localparam int RPT_POS = 7;
   localparam int RPT5_POS = 6;
   localparam int FLAG_WDF_POS = 7;
   localparam int FLAG_AF_POS = 6;
   localparam int SQ_OD_POS = 3;
   // ==========================================================
   // Reset values
   localparam logic [7:0] WDOG_RESET = 8'h00;
   localparam logic [7:0] ALARM_RESET = 8'h00;
   localparam logic [7:0] SQW_RESET = 8'h00;
   // ==========================================================
   // Alarm repeat codes, ordered ALARM_REPEAT_BITS
   localparam logic [4:0] RPT_SECOND = 5'h1F;
   localparam logic [4:0] RPT_MINUTE = 5'h1E;
   localparam logic [4:0] RPT_HOUR = 5'h1C;
   localparam logic [4:0] RPT_DAY = 5'h18;
   localparam logic [4:0] RPT_MONTH = 5'h10;
   localparam logic [4:0] RPT_YEAR = 5'h00;
   // ==========================================================
   // Time bases
   localparam int SYS_CLK_HZ = 10_000_000;
   localparam int PRESC_W = 15;
   localparam int WD_UNIT_W = 11;
   localparam int WD_CNT_W = 11;
   localparam int FT_TAP = 5;
   localparam int RECOVERY_HOLD_TIME_W = 21;
   localparam int RECOVERY_HOLD_TIME_DEF_MS = 96;
   localparam int RECOVERY_HOLD_TIME_ST_MS = 40;
   localparam int RECOVERY_HOLD_TIME_TR_MS = 50;
   localparam int RECOVERY_HOLD_TIME_DEF_CYC = RECOVERY_HOLD_TIME_DEF_MS * (SYS_CLK_HZ / 1000);
   localparam int RECOVERY_HOLD_TIME_ST_CYC = RECOVERY_HOLD_TIME_ST_MS * (SYS_CLK_HZ / 1000);
   localparam int RECOVERY_HOLD_TIME_TR_CYC = RECOVERY_HOLD_TIME_TR_MS * (SYS_CLK_HZ / 1000);

   typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_FIRED} wd_state_t;
endpackage : rtc_timing_pkg

// ===== design/rtc_alarm_watchdog_sqw.sv
/*
 * Alarm compare, watchdog, square-wave and 32 kHz outputs, and reset hold
 * of a serial clock and supervisor. Expects the serial engine to present
 * decoded byte transfers (pointer load, write, read) on sys_clk_i, the
 * time counters on the same clock, and raw oscillator and pin levels.
 */
// ==========================================================
// Summary of operation
// - Repeat code picks alarm compare fields
// - Undefined repeat codes alarm every second
// - Match sets alarm flag; enable drives interrupt
// - Pointer on flags defers alarm until moved
// - Flags read releases alarm interrupt; flag later
// - Backup interrupt needs backup and alarm enables
// - Power-up clears both alarm enables
// - Timeout is multiplier times selected resolution
// - Missed restart sets flag, then interrupt/reset
// - Steering picks interrupt or hold-time reset pulse
// - Reset-steered timeout end clears listed bits
// - Kick edge or register write restarts count
// - Kick or zero write releases watchdog interrupt
// - Flags read clears timeout flag, keeps interrupt
// - Power-up disables watchdog, clears its register
// - Rate code selects square-wave frequency
// - Enable bit gates square wave onto pin
// - Open-drain bit picks open drain or push-pull
// - 32 kHz runs unless disabled or stopped
// - Reset low on supply fail, held afterwards
// - Power-on reset clears listed enable bits
// - Alarm flag is read-only
// - Default hold time is 96 to 98 ms
`timescale 1ns/10ps
module rtc_alarm_watchdog_sqw
   import rtc_timing_pkg::*;
#(
   parameter int RECOVERY_HOLD_TIME_DEF_CYC_P = RECOVERY_HOLD_TIME_DEF_CYC,
   parameter int RECOVERY_HOLD_TIME_ST_CYC_P = RECOVERY_HOLD_TIME_ST_CYC,
   parameter int RECOVERY_HOLD_TIME_TR_CYC_P = RECOVERY_HOLD_TIME_TR_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic ptr_load_i,
   input wire logic [7:0] ptr_data_i,
   input wire logic wr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   input wire logic [6:0] time_sec_i,
   input wire logic [6:0] time_min_i,
   input wire logic [5:0] time_hour_i,
   input wire logic [5:0] time_date_i,
   input wire logic [4:0] time_month_i,
   input wire logic osc_clk_i,
   input wire logic watchdog_kick_input_i,
   input wire logic vcc_low_i,
   input wire logic hold_time_select_bit_i,
   input wire logic oscillator_stop_bit_i,
   input wire logic frequency_test_bit_i,
   input wire logic fixed_32k_enable_i,
   output logic ft_clear_o,
   output logic irq_o,
   output logic irq_oe_n_o,
   output logic rst_o,
   output logic rst_oe_n_o,
   output logic square_wave_pin_o,
   output logic square_wave_pin_oe_n_o,
   output logic fixed_32k_pin_o,
   output logic fixed_32k_pin_oe_n_o
);
   // ==========================================================
   // Declarations
   logic [7:0] ptr_r;
   logic [7:0] wd_reg_r;
   logic [7:0] al_r [0:4];
   logic [7:0] sqw_r;
   logic [2:0] osc_s_r, kick_s_r, vcc_s_r;
   logic osc_lvl_r, kick_lvl_r, backup_r, kick_edge_r;
   logic [PRESC_W-1:0] presc_r;
   logic osc_tick, sec_tick, unit_tick;
   logic flags_rd, wd_wr, alarm_wr_ok, deselect;
   logic al_match, deliver, alarm_pend_r, af_r, alarm_irq_r;
   logic afe, abe, square_out_enable;
   wd_state_t wd_state_r;
   logic [WD_CNT_W-1:0] wd_cnt_r;
   logic wd_fire, wdf_r, wd_irq_r, wd_rst_pend_r, wd_clear_ev;
   logic [RECOVERY_HOLD_TIME_W-1:0] rst_cnt_r;
   logic [2:0] al_idx;

   assign afe = al_r[0][AL_IRQ_EN_POS];
   assign square_out_enable = al_r[0][SQ_EN_POS];
   assign abe = al_r[0][BK_EN_POS];
   assign deselect = (rst_cnt_r != '0);
   assign flags_rd = rd_i && (ptr_r == ADDR_FLAGS);
   assign wd_wr = wr_i && !deselect && (ptr_r == ADDR_WATCHDOG);
   assign alarm_wr_ok = wr_i && !deselect && (ptr_r >= ADDR_ALARM_MONTH_CTRL) && (ptr_r <= ADDR_AL_SEC);
   assign al_idx = 3'(ptr_r - ADDR_ALARM_MONTH_CTRL);

   // ==========================================================
   // Functions
   function automatic logic alarm_hit(input logic [4:0] rpt, input logic s, input logic m,
                                      input logic h, input logic d, input logic mo);
      case (rpt)
         RPT_SECOND: alarm_hit = 1'b1;
         RPT_MINUTE: alarm_hit = s;
         RPT_HOUR: alarm_hit = s && m;
         RPT_DAY: alarm_hit = s && m && h;
         RPT_MONTH: alarm_hit = s && m && h && d;
         RPT_YEAR: alarm_hit = s && m && h && d && mo;
         default: alarm_hit = 1'b1; // Bad codes fire every second so they show up fast
      endcase
   endfunction : alarm_hit

   function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [7:0] reg_v);
      wd_limit = WD_CNT_W'({reg_v[6:2], 6'h00} >> (6 - 2 * reg_v[1:0]));
   endfunction : wd_limit

   function automatic logic [RECOVERY_HOLD_TIME_W-1:0] recovery_hold_time_cycles(input logic tr, input logic st);
      if (tr) begin
         recovery_hold_time_cycles = RECOVERY_HOLD_TIME_W'(RECOVERY_HOLD_TIME_TR_CYC_P);
      end else if (st) begin
         recovery_hold_time_cycles = RECOVERY_HOLD_TIME_W'(RECOVERY_HOLD_TIME_ST_CYC_P);
      end else begin
         recovery_hold_time_cycles = RECOVERY_HOLD_TIME_W'(RECOVERY_HOLD_TIME_DEF_CYC_P);
      end
   endfunction : recovery_hold_time_cycles

   // ==========================================================
   // Pin synchronisers: a change counts once stages two and three agree
   always_ff @(posedge sys_clk_i) begin
      osc_s_r <= {osc_s_r[1:0], osc_clk_i};
      kick_s_r <= {kick_s_r[1:0], watchdog_kick_input_i};
      vcc_s_r <= {vcc_s_r[1:0], vcc_low_i};
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         osc_lvl_r <= 1'b0;
         kick_lvl_r <= 1'b0;
         backup_r <= 1'b0;
         kick_edge_r <= 1'b0;
      end else begin
         if (osc_s_r[1] == osc_s_r[2]) begin
            osc_lvl_r <= osc_s_r[2];
         end
         if (vcc_s_r[1] == vcc_s_r[2]) begin
            backup_r <= vcc_s_r[2];
         end
         if (kick_s_r[1] == kick_s_r[2]) begin
            kick_lvl_r <= kick_s_r[2];
         end
         // Either direction counts as a kick
         kick_edge_r <= (kick_s_r[1] == kick_s_r[2]) && (kick_s_r[2] != kick_lvl_r);
      end
   end

   // ==========================================================
   // Oscillator divider
   assign osc_tick = (osc_s_r[1] == osc_s_r[2]) && osc_s_r[2] && !osc_lvl_r;
   assign sec_tick = osc_tick && (&presc_r);
   assign unit_tick = osc_tick && (&presc_r[WD_UNIT_W-1:0]);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         presc_r <= '0;
      end else if (osc_tick) begin
         presc_r <= presc_r + 1'b1;
      end
   end

   // ==========================================================
   // Address pointer of the serial engine
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ptr_r <= 8'h00;
      end else if (ptr_load_i) begin
         ptr_r <= ptr_data_i;
      end else if (wr_i || rd_i) begin
         ptr_r <= ptr_r + 8'h01;
      end
   end

   // ==========================================================
   // Register file; writes are ignored during the deselect hold
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < 5; i++) begin
            al_r[i] <= ALARM_RESET; // Alarm enables cleared at power-up
         end
         sqw_r <= SQW_RESET;
      end else if (wd_clear_ev) begin
         al_r[0][AL_IRQ_EN_POS] <= 1'b0;
         al_r[0][SQ_EN_POS] <= 1'b0;
         al_r[0][BK_EN_POS] <= 1'b0;
      end else if (alarm_wr_ok) begin
         al_r[al_idx] <= wr_data_i; // Zero date plus zero repeat never matches
      end else if (wr_i && !deselect && (ptr_r == ADDR_SQW)) begin
         sqw_r <= {wr_data_i[7:3], 3'h0};
      end
   end

   // Flags register has no write path at all
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_i) begin
         if (ptr_r == ADDR_WATCHDOG) begin
            rd_data_o <= wd_reg_r;
         end else if ((ptr_r >= ADDR_ALARM_MONTH_CTRL) && (ptr_r <= ADDR_AL_SEC)) begin
            rd_data_o <= al_r[al_idx];
         end else if (ptr_r == ADDR_FLAGS) begin
            // Returns the flag as it stood; the clear shows on a later read
            rd_data_o <= {wdf_r, af_r, 6'h00};
         end else if (ptr_r == ADDR_SQW) begin
            rd_data_o <= sqw_r;
         end else begin
            rd_data_o <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Alarm
   assign al_match = sec_tick && alarm_hit({al_r[1][RPT5_POS], al_r[1][RPT_POS], al_r[2][RPT_POS],
                                            al_r[3][RPT_POS], al_r[4][RPT_POS]},
                                           time_sec_i == al_r[4][6:0], time_min_i == al_r[3][6:0],
                                           time_hour_i == al_r[2][5:0],
                                           time_date_i == al_r[1][5:0],
                                           time_month_i == al_r[0][4:0]);
   // A match waits here while the pointer sits on the flags address
   assign deliver = alarm_pend_r && (ptr_r != ADDR_FLAGS);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         alarm_pend_r <= 1'b0;
      end else if (al_match) begin
         alarm_pend_r <= 1'b1;
      end else if (deliver) begin
         alarm_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         af_r <= 1'b0;
      end else if (deliver) begin
         af_r <= 1'b1; // Set beats a same-cycle read clear
      end else if (flags_rd) begin
         af_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         alarm_irq_r <= 1'b0;
      end else if (deliver && afe && (!backup_r || abe)) begin
         alarm_irq_r <= 1'b1;
      end else if (flags_rd) begin
         alarm_irq_r <= 1'b0;
      end
   end

   // ==========================================================
   // Watchdog
   assign wd_fire = (wd_state_r == WD_RUN) && unit_tick && !wd_wr && !kick_edge_r &&
                    ((wd_cnt_r + 1'b1) == wd_limit(wd_reg_r));

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         wd_reg_r <= WDOG_RESET;
         wd_state_r <= WD_OFF;
         wd_cnt_r <= '0;
      end else if (wd_clear_ev) begin
         wd_reg_r <= WDOG_RESET;
         wd_state_r <= WD_OFF;
         wd_cnt_r <= '0;
      end else if (wd_wr) begin
         wd_reg_r <= wr_data_i; // Any write restarts; a zero multiplier field stops
         wd_state_r <= (wr_data_i[6:2] != 5'h00) ? WD_RUN : WD_OFF;
         wd_cnt_r <= '0;
      end else begin
         case (wd_state_r)
            WD_OFF: wd_cnt_r <= '0;
            WD_RUN, WD_FIRED: begin
               if (kick_edge_r) begin
                  wd_state_r <= WD_RUN;
                  wd_cnt_r <= '0;
               end else if (wd_fire) begin
                  wd_state_r <= WD_FIRED;
               end else if (unit_tick && (wd_state_r == WD_RUN)) begin
                  wd_cnt_r <= wd_cnt_r + 1'b1;
               end
            end
            default: wd_state_r <= WD_OFF;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         wdf_r <= 1'b0;
      end else if (wd_fire) begin
         wdf_r <= 1'b1;
      end else if (flags_rd) begin
         wdf_r <= 1'b0;
      end
   end

   // A flags read leaves this one alone on purpose
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         wd_irq_r <= 1'b0;
      end else if (wd_fire && !wd_reg_r[WD_STEER_POS]) begin
         wd_irq_r <= 1'b1;
      end else if (kick_edge_r || (wd_wr && (wr_data_i == 8'h00))) begin
         wd_irq_r <= 1'b0;
      end
   end

   // ==========================================================
   // Reset hold: power-up, supply fail and reset-steered timeout
   assign wd_clear_ev = wd_rst_pend_r && (rst_cnt_r == RECOVERY_HOLD_TIME_W'(1)) && !backup_r;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rst_cnt_r <= RECOVERY_HOLD_TIME_W'(RECOVERY_HOLD_TIME_DEF_CYC_P);
      end else if (backup_r || (wd_fire && wd_reg_r[WD_STEER_POS])) begin
         // Reloaded while the supply is low, so the hold counts from recovery
         rst_cnt_r <= recovery_hold_time_cycles(hold_time_select_bit_i, oscillator_stop_bit_i);
      end else if (rst_cnt_r != '0) begin
         rst_cnt_r <= rst_cnt_r - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         wd_rst_pend_r <= 1'b0;
         ft_clear_o <= 1'b0;
      end else begin
         ft_clear_o <= wd_clear_ev;
         if (wd_fire && wd_reg_r[WD_STEER_POS]) begin
            wd_rst_pend_r <= 1'b1;
         end else if (wd_clear_ev || backup_r) begin
            wd_rst_pend_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Pins; oe_n low means the pin is driven
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
         irq_oe_n_o <= 1'b1;
         rst_o <= 1'b0;
         rst_oe_n_o <= 1'b0;
         square_wave_pin_o <= 1'b0;
         square_wave_pin_oe_n_o <= 1'b1;
         fixed_32k_pin_o <= 1'b0;
         fixed_32k_pin_oe_n_o <= 1'b1;
      end else begin
         irq_o <= 1'b0;
         irq_oe_n_o <= !(alarm_irq_r || wd_irq_r);
         rst_o <= 1'b0;
         rst_oe_n_o <= !deselect;
         fixed_32k_pin_o <= 1'b0;
         // Open drain: only the low half is driven
         fixed_32k_pin_oe_n_o <= !(fixed_32k_enable_i && !oscillator_stop_bit_i) || osc_lvl_r;
         if (square_out_enable && (sqw_r[7:4] != 4'h0)) begin
            square_wave_pin_o <= sqw_od_lvl(sqw_r, presc_r, osc_lvl_r, 1'b0);
            square_wave_pin_oe_n_o <= sqw_od_lvl(sqw_r, presc_r, osc_lvl_r, 1'b1);
         end else if (!square_out_enable && frequency_test_bit_i && !oscillator_stop_bit_i) begin
            square_wave_pin_o <= sqw_r[SQ_OD_POS] ? 1'b0 : presc_r[FT_TAP];
            square_wave_pin_oe_n_o <= sqw_r[SQ_OD_POS] && presc_r[FT_TAP];
         end else begin
            square_wave_pin_o <= 1'b0;
            square_wave_pin_oe_n_o <= 1'b1;
         end
      end
   end

   // Level for the rate code; oe selects the enable rather than the data
   function automatic logic sqw_od_lvl(input logic [7:0] cfg, input logic [PRESC_W-1:0] p,
                                       input logic osc, input logic oe);
      logic lvl;
      lvl = (cfg[7:4] == 4'h1) ? osc : p[4'(cfg[7:4] - 4'h1)];
      if (cfg[SQ_OD_POS]) begin
         sqw_od_lvl = oe ? lvl : 1'b0;
      end else begin
         sqw_od_lvl = oe ? 1'b0 : lvl;
      end
   endfunction : sqw_od_lvl

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   sequence seq_wd_irq_path;
      wd_irq_r ##1 !irq_oe_n_o;
   endsequence

   chk_alarm_sets_flag: assert property (deliver |=> af_r)
      else $error("alarm flag not set after match");
   chk_pointer_holdoff: assert property ($rose(af_r) |-> $past(ptr_r) != ADDR_FLAGS)
      else $error("alarm flag set while pointer on flags");
   chk_read_releases: assert property (flags_rd && !deliver |=> !alarm_irq_r)
      else $error("flags read did not release alarm interrupt");
   chk_backup_gate: assert property ($rose(alarm_irq_r) |-> $past(afe) &&
                                     (!$past(backup_r) || $past(abe)))
      else $error("alarm interrupt without required enables");
   chk_wd_fire_flag: assert property (wd_fire |=> wdf_r)
      else $error("timeout flag not set");
   chk_wd_irq_steer: assert property (wd_fire && !wd_reg_r[WD_STEER_POS] |=> seq_wd_irq_path)
      else $error("interrupt-steered timeout did not drive interrupt");
   chk_wdf_read_keeps: assert property (flags_rd && wd_irq_r && !kick_edge_r && !wd_wr
                                        && !wd_fire |=> !wdf_r && wd_irq_r)
      else $error("flags read mishandled watchdog state");
   chk_wd_zero_release: assert property (wd_wr && wr_data_i == 8'h00 |=> !wd_irq_r &&
                                         wd_state_r == WD_OFF)
      else $error("zero write did not release watchdog");
   chk_wd_reset_pulse: assert property (wd_fire && wd_reg_r[WD_STEER_POS] |=> ##1 !rst_oe_n_o)
      else $error("reset-steered timeout did not pull reset");
   chk_wd_clear_end: assert property (wd_clear_ev |=> wd_reg_r == 8'h00 && !afe && !abe &&
                                      !square_out_enable && ft_clear_o)
      else $error("timeout end did not clear bits");
endmodule : rtc_alarm_watchdog_sqw

// ===== verif/host_model.sv
/*
 Host processor on the decoded register byte port of the timing block.
 Assumes the block samples on the rising edge; the host moves on the falling one.
*/
`timescale 1ns/10ps
module host_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] rd_data_i,
   output logic ptr_load_o,
   output logic [7:0] ptr_data_o,
   output logic wr_o,
   output logic [7:0] wr_data_o,
   output logic rd_o
);
   initial begin
      {ptr_load_o, wr_o, rd_o} = 3'h0;
      ptr_data_o = 8'h00;
      wr_data_o = 8'h00;
   end
   // ==========================================================
   // Byte transfers; released buses carry the inverse so stale values never pass
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i) {ptr_load_o, ptr_data_o} = {1'b1, a};
      @(negedge sys_clk_i) {ptr_load_o, wr_o, wr_data_o} = {2'b01, d};
      @(negedge sys_clk_i) {wr_o, ptr_data_o, wr_data_o} = {1'b0, ~a, ~d};
   endtask : write_reg
   // Reading flags steps the pointer on to 10h, so alarms are held off for one cycle only
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk_i) {ptr_load_o, ptr_data_o} = {1'b1, a};
      @(negedge sys_clk_i) {ptr_load_o, rd_o} = 2'b01;
      @(negedge sys_clk_i) {rd_o, ptr_data_o} = {1'b0, ~a};
      d = rd_data_i;
   endtask : read_reg
endmodule : host_model

// ===== verif/rtc_alarm_watchdog_sqw_tb.sv
/*
 Testbench of the timing block: reset hold, watchdog, square wave, 32 kHz.
 Assumes a sped-up oscillator of 8 system cycles; second-long alarms stay unrun.
*/
`timescale 1ns/10ps
module rtc_alarm_watchdog_sqw_tb;
   import rtc_timing_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic osc_clk_i = 1'b0;
   logic watchdog_kick_input_i = 1'b0;
   logic vcc_low_i = 1'b0;
   logic oscillator_stop_bit_i = 1'b0;
   logic fixed_32k_enable_i = 1'b0;
   logic hold_time_select_bit_i = 1'b0;
   logic frequency_test_bit_i = 1'b0;
   logic [6:0] time_sec_i = 7'h00, time_min_i = 7'h00;
   logic [5:0] time_hour_i = 6'h00, time_date_i = 6'h01;
   logic [4:0] time_month_i = 5'h01;
   logic ptr_load_i, wr_i, rd_i, ft_clear_o, irq_o, irq_oe_n_o, rst_o, rst_oe_n_o;
   logic square_wave_pin_o, square_wave_pin_oe_n_o, fixed_32k_pin_o, fixed_32k_pin_oe_n_o;
   logic ft_seen = 1'b0;
   logic [7:0] ptr_data_i, wr_data_i, rd_data_o, d;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   int n_sq, n_oe, n_32;
   initial forever #50 sys_clk_i = ~sys_clk_i;
   initial forever #400 osc_clk_i = ~osc_clk_i;
   rtc_alarm_watchdog_sqw #(.RECOVERY_HOLD_TIME_DEF_CYC_P(20), .RECOVERY_HOLD_TIME_ST_CYC_P(30), .RECOVERY_HOLD_TIME_TR_CYC_P(40)) DUT (
      .sys_clk_i, .reset_i, .ptr_load_i, .ptr_data_i, .wr_i, .wr_data_i, .rd_i, .rd_data_o,
      .time_sec_i, .time_min_i, .time_hour_i, .time_date_i,
      .time_month_i, .osc_clk_i, .watchdog_kick_input_i, .vcc_low_i,
      .hold_time_select_bit_i, .oscillator_stop_bit_i, .frequency_test_bit_i,
      .fixed_32k_enable_i, .ft_clear_o, .irq_o, .irq_oe_n_o, .rst_o, .rst_oe_n_o,
      .square_wave_pin_o, .square_wave_pin_oe_n_o, .fixed_32k_pin_o, .fixed_32k_pin_oe_n_o);
   host_model HOST (.sys_clk_i, .rd_data_i(rd_data_o), .ptr_load_o(ptr_load_i),
      .ptr_data_o(ptr_data_i), .wr_o(wr_i), .wr_data_o(wr_data_i), .rd_o(rd_i));
   // ==========================================================
   // Shared helpers
   task automatic conclude();
      if (n_mismatch == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   // Ceiling sits above the four watchdog unit ticks the run needs
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (ft_clear_o === 1'b1) ft_seen <= 1'b1;
      if (cycles == 90000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wait_oe(input bit on_rst, input logic lvl, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(negedge sys_clk_i);
         if ((on_rst ? rst_oe_n_o : irq_oe_n_o) === lvl) break;
      end
   endtask : wait_oe
   task automatic count_tog();
      logic a, b, c;
      // Let the registered pins settle after the last control change
      repeat (2) @(negedge sys_clk_i);
      {a, b, c} = {square_wave_pin_o, square_wave_pin_oe_n_o, fixed_32k_pin_oe_n_o};
      {n_sq, n_oe, n_32} = {32'd0, 32'd0, 32'd0};
      repeat (800) begin
         @(negedge sys_clk_i);
         n_sq += (square_wave_pin_o !== a);
         n_oe += (square_wave_pin_oe_n_o !== b);
         n_32 += (fixed_32k_pin_oe_n_o !== c);
         {a, b, c} = {square_wave_pin_o, square_wave_pin_oe_n_o, fixed_32k_pin_oe_n_o};
      end
   endtask : count_tog
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      repeat (16) @(negedge sys_clk_i);
      reset_i = 1'b0;
      repeat (10) @(negedge sys_clk_i);
      check("rst_hold", 1'b0, rst_oe_n_o);
      HOST.read_reg(ADDR_WATCHDOG, d);
      check("wdog_reset", WDOG_RESET, d);
      HOST.read_reg(ADDR_ALARM_MONTH_CTRL, d);
      check("almon_reset", ALARM_RESET, d);
      HOST.read_reg(ADDR_SQW, d);
      check("sqw_reset", SQW_RESET, d);
      wait_oe(1, 1'b1, 40);
      check("rst_end", 1'b1, rst_oe_n_o);
      vcc_low_i = 1'b1;
      hold_time_select_bit_i = 1'b1;
      wait_oe(1, 1'b0, 20);
      check("rst_supply", 1'b0, rst_oe_n_o);
      vcc_low_i = 1'b0;
      wait_oe(1, 1'b1, 30);
      check("rst_tr_hold", 1'b0, rst_oe_n_o);
      wait_oe(1, 1'b1, 60);
      check("rst_again", 1'b1, rst_oe_n_o);
      hold_time_select_bit_i = 1'b0;
      HOST.write_reg(ADDR_FLAGS, 8'hFF);
      HOST.read_reg(ADDR_FLAGS, d);
      check("flags_ro", 8'h00, d);
      HOST.write_reg(ADDR_ALARM_MONTH_CTRL + 8'h01, 8'h00);
   endtask : t_reset
   task automatic t_wd_irq();
      HOST.write_reg(ADDR_WATCHDOG, 8'h04);
      repeat (12000) @(negedge sys_clk_i);
      check("wd_early", 1'b1, irq_oe_n_o);
      wait_oe(0, 1'b0, 20000);
      check("wd_irq", 1'b0, irq_oe_n_o);
      HOST.read_reg(ADDR_FLAGS, d);
      check("wdf_set", 8'h01 << FLAG_WDF_POS, d);
      check("wd_irq_kept", 1'b0, irq_oe_n_o);
      HOST.read_reg(ADDR_FLAGS, d);
      check("wdf_clear", 8'h00, d);
      HOST.write_reg(ADDR_WATCHDOG, 8'h00);
      wait_oe(0, 1'b1, 10);
      check("wd_irq_off", 1'b1, irq_oe_n_o);
   endtask : t_wd_irq
   task automatic t_wd_kick();
      // Two units: unkicked, the free-running unit tick fires within this time
      HOST.write_reg(ADDR_WATCHDOG, 8'h08);
      repeat (5) begin
         repeat (8000) @(negedge sys_clk_i);
         watchdog_kick_input_i = ~watchdog_kick_input_i;
      end
      check("kick_restart", 1'b1, irq_oe_n_o);
      HOST.write_reg(ADDR_WATCHDOG, 8'h00);
   endtask : t_wd_kick
   task automatic t_wd_reset();
      HOST.write_reg(ADDR_ALARM_MONTH_CTRL, 8'h60);
      HOST.write_reg(ADDR_WATCHDOG, 8'h84);
      wait_oe(1, 1'b0, 30000);
      check("wd_rst", 1'b0, rst_oe_n_o);
      check("wd_no_irq", 1'b1, irq_oe_n_o);
      wait_oe(1, 1'b1, 60);
      HOST.read_reg(ADDR_WATCHDOG, d);
      check("wd_cleared", 8'h00, d);
      HOST.read_reg(ADDR_ALARM_MONTH_CTRL, d);
      check("en_cleared", 8'h00, d);
      check("ft_clear", 1'b1, ft_seen);
   endtask : t_wd_reset
   task automatic t_sqw();
      HOST.write_reg(ADDR_SQW, 8'h10);
      HOST.write_reg(ADDR_ALARM_MONTH_CTRL, 8'h40);
      count_tog();
      check("sq_32k", 1'b1, n_sq > 190 && n_sq < 210 && n_oe == 0);
      HOST.write_reg(ADDR_SQW, 8'h20);
      count_tog();
      check("sq_8k", 1'b1, n_sq > 45 && n_sq < 55);
      HOST.write_reg(ADDR_SQW, 8'h28);
      count_tog();
      check("sq_od", 1'b1, n_oe > 45 && n_oe < 55 && square_wave_pin_o === 1'b0);
      HOST.write_reg(ADDR_ALARM_MONTH_CTRL, 8'h00);
      count_tog();
      check("sq_off", 1'b1, n_oe == 0 && square_wave_pin_oe_n_o === 1'b1);
      frequency_test_bit_i = 1'b1;
      count_tog();
      check("sq_ft", 1'b1, n_oe > 1 && n_oe < 5 && square_wave_pin_o === 1'b0);
      frequency_test_bit_i = 1'b0;
   endtask : t_sqw
   task automatic t_32k();
      fixed_32k_enable_i = 1'b1;
      count_tog();
      check("f32_on", 1'b1, n_32 > 190 && n_32 < 210);
      oscillator_stop_bit_i = 1'b1;
      count_tog();
      check("f32_stop", 1'b1, n_32 == 0 && fixed_32k_pin_oe_n_o === 1'b1);
      {oscillator_stop_bit_i, fixed_32k_enable_i} = 2'b00;
      count_tog();
      check("f32_off", 1'b1, n_32 == 0 && fixed_32k_pin_oe_n_o === 1'b1);
   endtask : t_32k
   initial begin
      t_reset();
      t_wd_irq();
      t_wd_kick();
      t_wd_reset();
      t_sqw();
      t_32k();
      conclude();
   end
endmodule : rtc_alarm_watchdog_sqw_tb
